// File: dv/ppc_cpu_model.sv
// processor-side model issuing register writes and reads to the bank
`timescale 1ns/100ps
module ppc_cpu_model (
   input wire logic ref_clk_in,
   input ppc_pkg::ppc_rsp_type rsp_in,
   output ppc_pkg::ppc_req_type req_out
);
   import ppc_pkg::*;
   initial req_out = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = (a == 8'hE6) ? (d & 8'h0F) : d;
      @(posedge ref_clk_in);
      req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge ref_clk_in);
      // released bus lines show the inverse, never the stale value
      req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_in);
      req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      d = 8'hXX;
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk_in);
         if (rsp_in.valid === 1'b1) begin
            d = rsp_in.rdata;
            break;
         end
      end
      // one spare edge keeps register reads three cycles apart, string reads four
      @(posedge ref_clk_in);
   endtask
endmodule

// File: dv/ppc_regs_tb.sv
// self-checking bench for the port power and charging register bank
`timescale 1ns/100ps
module ppc_regs_tb;
   import ppc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic [2:0] host_q = 3'h0;
   logic sel_q = 1'b0;
   logic pin_low_q = 1'b1;
   ppc_req_type req;
   ppc_rsp_type rsp;
   logic [2:0] chg;
   logic [2:0] pwr;
   logic [2:0] ocr;
   logic busy;
   int mismatches = 0;
   int comparisons = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   ppc_regs u_dut (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .req_in(req),
      .rsp_out(rsp),
      .host_port_power_in(host_q),
      .over_current_pin_select_in(sel_q),
      .over_current_sense_pin_low_in(pin_low_q),
      .charging_enable_out(chg),
      .port_power_out(pwr),
      .over_current_report_out(ocr),
      .init_busy_out(busy)
   );
   ppc_cpu_model u_cpu (
      .ref_clk_in(ref_clk_in),
      .rsp_in(rsp),
      .req_out(req)
   );
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // a bank that never leaves its clear walk counts as a mismatch
   task automatic wait_init;
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge ref_clk_in);
      chk("init done", {7'h00, busy}, 8'h00);
      @(posedge ref_clk_in);
   endtask
   // port 3 comes from the pin when selected, else from the register bit
   function automatic logic [2:0] active_oc(input logic [2:0] oc, input logic sel,
                                            input logic pin_low);
      return {sel ? ~pin_low : oc[2], oc[1:0]};
   endfunction
   initial begin
      #800000;
      mismatches++;
      print_verdict();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] v;
      logic [15:0] ch;
      logic [2:0] oc;
      int chars[3] = '{0, 7, 30};
      void'($urandom(3741));
      repeat (16) @(posedge ref_clk_in);
      chk("reset power", {5'h00, pwr}, 8'h00);
      chk("reset busy", {7'h00, busy}, 8'h01);
      rst_in <= 1'b0;
      wait_init();
      foreach (chars[k]) begin
         ch = 16'($urandom);
         u_cpu.wr(8'h92 + 8'(2 * chars[k]), ch[7:0]);
         u_cpu.wr(8'h93 + 8'(2 * chars[k]), ch[15:8]);
         u_cpu.rd(8'h92 + 8'(2 * chars[k]), d);
         chk("string low byte", d, ch[7:0]);
         u_cpu.rd(8'h93 + 8'(2 * chars[k]), d);
         chk("string high byte", d, ch[15:8]);
      end
      u_cpu.rd(8'h94, d);
      chk("string unwritten", d, 8'h00);
      u_cpu.rd(8'hD1, d);
      chk("unmapped", d, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         u_cpu.wr(8'hD0, v);
         u_cpu.rd(8'hD0, d);
         chk("charging reg", d, v & 8'h0E);
         chk("charging out", {5'h00, chg}, {5'h00, v[3:1]});
      end
      for (int i = 0; i < 24; i++) begin
         v = (i < 2) ? 8'hFF : 8'($urandom);
         @(posedge ref_clk_in);
         host_q <= 3'($urandom);
         sel_q <= i[0];
         pin_low_q <= 1'($urandom);
         u_cpu.wr(8'hE6, v);
         // status writes must not steer port power
         u_cpu.wr(8'hE5, ~v);
         repeat (4) @(posedge ref_clk_in);
         oc = active_oc(v[3:1], sel_q, pin_low_q);
         chk("oc report", {5'h00, ocr}, {5'h00, oc});
         chk("port power", {5'h00, pwr}, {5'h00, host_q & ~oc});
         u_cpu.rd(8'hE5, d);
         chk("power status", d, {4'h0, host_q & ~oc, 1'b0});
         u_cpu.rd(8'hE6, d);
         chk("oc reg", d, {4'h0, v[3:1], 1'b0});
      end
      // clock enable low must freeze the power output against a host change
      @(posedge ref_clk_in);
      v = {5'h00, pwr};
      ce_in <= 1'b0;
      host_q <= ~host_q;
      repeat (4) @(posedge ref_clk_in);
      chk("frozen power", {5'h00, pwr}, v);
      ce_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      chk("thawed power", {5'h00, pwr}, {5'h00, host_q & ~oc});
      // second reset in mid-run: pin parked idle so the synchroniser agrees
      pin_low_q <= 1'b1;
      rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      chk("mid reset power", {5'h00, pwr}, 8'h00);
      chk("mid reset charging", {5'h00, chg}, 8'h00);
      chk("mid reset busy", {7'h00, busy}, 8'h01);
      rst_in <= 1'b0;
      wait_init();
      u_cpu.rd(8'h92 + 8'(2 * chars[2]), d);
      chk("string cleared", d, 8'h00);
      u_cpu.rd(8'hE5, d);
      chk("status after reset", d, {4'h0, host_q & ~active_oc(3'h0, sel_q, 1'b1), 1'b0});
      print_verdict();
   end
endmodule

// File: verilog/ppc_cfg.svh
// register map, field positions and reset values of the port power and charging bank
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_SER_FIRST 8'h92
`define PPC_SER_LAST 8'hCF
`define PPC_SER_DEPTH 64
`define PPC_SER_AW 6
`define PPC_CHG_EN_ADDR 8'hD0
`define PPC_PWR_STAT_ADDR 8'hE5
`define PPC_OC_CTRL_ADDR 8'hE6
`define PPC_PORT_LSB 1
`define PPC_PORT_MSB 3
`define PPC_PORT3 2
`define PPC_BYTE_RST 8'h00
`define PPC_PORTS_RST 3'h0
`endif

// File: verilog/ppc_pkg.sv
// types shared by the port power and charging bank
package ppc_pkg;
   typedef logic [2:0] ppc_ports_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ppc_req_type;
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } ppc_rsp_type;
   typedef enum logic [2:0] {
      PPC_IDLE = 3'b001,
      PPC_SER_WAIT = 3'b010,
      PPC_DONE = 3'b100
   } ppc_rd_state_type;
endpackage

// File: verilog/ppc_regs.sv
// port power, charging enable, over-current and serial string registers
//
// Operation
// - serial string bytes from 92h, low first
// - charging enable bits 3:1 are ports
// - charging bit one enables port charging
// - power status bits 3:1 read-only
// - status zero if unpowered or over-current
// - port power from host and over-current only
// - pin select one: pin senses port 3
// - pin select zero: register bit port 3
// - bits 2:1 report ports 2, 1
// - over-current bit one means over-current
// - active over-current clears power status bit
// - pin select picks pin or register
`timescale 1ns/100ps
`include "ppc_cfg.svh"
module ppc_regs (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input ppc_pkg::ppc_req_type req_in,
   output ppc_pkg::ppc_rsp_type rsp_out,
   input wire logic [2:0] host_port_power_in,
   input wire logic over_current_pin_select_in,
   input wire logic over_current_sense_pin_low_in,
   output logic [2:0] charging_enable_out,
   output logic [2:0] port_power_out,
   output logic [2:0] over_current_report_out,
   output logic init_busy_out
);
   import ppc_pkg::*;

   function automatic logic in_ser(input logic [7:0] a);
      in_ser = (a >= `PPC_SER_FIRST) && (a <= `PPC_SER_LAST);
   endfunction

   function automatic logic [7:0] ports_to_byte(input ppc_ports_type p);
      ports_to_byte = {4'h0, p, 1'b0};
   endfunction

   // pin synchroniser
   logic oc_pin_s1_q;
   logic oc_pin_s2_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         oc_pin_s1_q <= 1'b1;
         oc_pin_s2_q <= 1'b1;
      end else if (ce_in) begin
         oc_pin_s1_q <= over_current_sense_pin_low_in;
         oc_pin_s2_q <= oc_pin_s1_q;
      end
   end

   // clear walk of the string memory after reset
   logic init_q;
   logic [`PPC_SER_AW-1:0] init_addr_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         init_q <= 1'b1;
         init_addr_q <= '0;
      end else if (ce_in && init_q) begin
         init_addr_q <= init_addr_q + 1'b1;
         if (init_addr_q == `PPC_SER_AW'(`PPC_SER_DEPTH - 1)) begin
            init_q <= 1'b0;
         end
      end
   end

   logic wr_ok;
   logic rd_ok;
   assign wr_ok = req_in.wr && !init_q;
   assign rd_ok = req_in.rd && !init_q && !req_in.wr;

   logic ser_hit;
   logic [7:0] ser_off;
   logic [`PPC_SER_AW-1:0] mem_addr;
   logic [7:0] mem_rdata;
   assign ser_hit = in_ser(req_in.addr);
   assign ser_off = req_in.addr - `PPC_SER_FIRST;
   // contiguous byte offset keeps each character low byte then high byte
   assign mem_addr = init_q ? init_addr_q : ser_off[`PPC_SER_AW-1:0];

   ppc_ser_mem #(
      .DEPTH(`PPC_SER_DEPTH),
      .AW(`PPC_SER_AW)
   ) u_ser_mem (
      .ref_clk_in(ref_clk_in),
      .ce_in(ce_in),
      .wr_in(init_q || (wr_ok && ser_hit)),
      .addr_in(mem_addr),
      .wdata_in(init_q ? `PPC_BYTE_RST : req_in.wdata),
      .rdata_out(mem_rdata)
   );

   // charging enable
   logic [2:0] chg_en_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         chg_en_q <= `PPC_PORTS_RST;
      end else if (ce_in && wr_ok && req_in.addr == `PPC_CHG_EN_ADDR) begin
         chg_en_q <= req_in.wdata[`PPC_PORT_MSB:`PPC_PORT_LSB];
      end
   end

   // over-current control; reserved bits never stored so a stray one is harmless
   logic [2:0] oc_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         oc_q <= `PPC_PORTS_RST;
      end else if (ce_in && wr_ok && req_in.addr == `PPC_OC_CTRL_ADDR) begin
         oc_q <= req_in.wdata[`PPC_PORT_MSB:`PPC_PORT_LSB];
      end
   end

   // active over-current per port: port 3 source follows the pin select
   ppc_ports_type oc_active;
   always_comb begin
      oc_active = oc_q;
      if (over_current_pin_select_in) begin
         oc_active[`PPC_PORT3] = !oc_pin_s2_q;
      end else begin
         oc_active[`PPC_PORT3] = oc_q[`PPC_PORT3];
      end
   end

   // status writes are ignored: no write path reaches this flop
   logic [2:0] pwr_stat_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwr_stat_q <= `PPC_PORTS_RST;
      end else if (ce_in) begin
         pwr_stat_q <= host_port_power_in & ~oc_active;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         charging_enable_out <= `PPC_PORTS_RST;
         port_power_out <= `PPC_PORTS_RST;
         over_current_report_out <= `PPC_PORTS_RST;
      end else if (ce_in) begin
         charging_enable_out <= chg_en_q;
         port_power_out <= host_port_power_in & ~oc_active;
         over_current_report_out <= oc_active;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         init_busy_out <= 1'b1;
      end else if (ce_in) begin
         init_busy_out <= init_q;
      end
   end

   // read answer: registers in one cycle, string memory in two
   ppc_rd_state_type rd_st_q;
   logic [7:0] rd_byte;
   always_comb begin
      case (req_in.addr)
         `PPC_CHG_EN_ADDR: rd_byte = ports_to_byte(chg_en_q);
         `PPC_PWR_STAT_ADDR: rd_byte = ports_to_byte(pwr_stat_q);
         `PPC_OC_CTRL_ADDR: rd_byte = ports_to_byte(oc_q);
         default: rd_byte = `PPC_BYTE_RST;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_st_q <= PPC_IDLE;
         rsp_out <= '0;
      end else if (ce_in) begin
         case (rd_st_q)
            PPC_IDLE: begin
               rsp_out.valid <= 1'b0;
               if (rd_ok && ser_hit) begin
                  rd_st_q <= PPC_SER_WAIT;
               end else if (rd_ok) begin
                  rsp_out.valid <= 1'b1;
                  rsp_out.rdata <= rd_byte;
                  rd_st_q <= PPC_DONE;
               end
            end
            PPC_SER_WAIT: begin
               rsp_out.valid <= 1'b1;
               rsp_out.rdata <= mem_rdata;
               rd_st_q <= PPC_DONE;
            end
            PPC_DONE: begin
               rsp_out.valid <= 1'b0;
               rd_st_q <= PPC_IDLE;
            end
            default: begin
               rsp_out.valid <= 1'b0;
               rd_st_q <= PPC_IDLE;
            end
         endcase
      end
   end

   // checks
   sequence s_oc_set;
      ce_in && oc_active[0] && host_port_power_in[0];
   endsequence

   property p_pwr_clear;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && !init_q ##1 ce_in ##0 $past(oc_active[0], 1) |-> !pwr_stat_q[0];
   endproperty
   a_pwr_clear: assert property (p_pwr_clear) else $error("status set under over-current");

   property p_pwr_follow;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && host_port_power_in == 3'h7 && oc_active == 3'h0 ##1 ce_in
         |-> pwr_stat_q == 3'h7;
   endproperty
   a_pwr_follow: assert property (p_pwr_follow) else $error("status not following host");

   property p_unpowered;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && !host_port_power_in[1] ##1 ce_in |-> !pwr_stat_q[1];
   endproperty
   a_unpowered: assert property (p_unpowered) else $error("status set while unpowered");

   property p_pin_sel;
      @(posedge ref_clk_in) disable iff (rst_in)
      // pin to report: two synchroniser flops, then the report flop
      ce_in ##1 ce_in ##1 ce_in && over_current_pin_select_in
         |=> over_current_report_out[`PPC_PORT3] == !$past(over_current_sense_pin_low_in, 3);
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("port 3 not from pin");

   property p_reg_sel;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && !over_current_pin_select_in
         |=> over_current_report_out[`PPC_PORT3] == $past(oc_q[`PPC_PORT3], 1);
   endproperty
   a_reg_sel: assert property (p_reg_sel) else $error("port 3 not from register");

   property p_low_ports;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in ##1 ce_in |-> over_current_report_out[1:0] == $past(oc_q[1:0], 1);
   endproperty
   a_low_ports: assert property (p_low_ports) else $error("ports 1,2 report wrong");

   property p_chg_map;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && wr_ok && req_in.addr == `PPC_CHG_EN_ADDR ##1 ce_in
         |-> chg_en_q == $past(req_in.wdata[3:1], 1);
   endproperty
   a_chg_map: assert property (p_chg_map) else $error("charging enable map wrong");

   property p_rsvd;
      @(posedge ref_clk_in) disable iff (rst_in)
      ce_in && rd_ok && !ser_hit && rd_st_q == PPC_IDLE
         |=> rsp_out.valid && rsp_out.rdata[7:4] == 4'h0 && !rsp_out.rdata[0];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   property p_no_pwr_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      s_oc_set |=> !port_power_out[0];
   endproperty
   a_no_pwr_write: assert property (p_no_pwr_write) else $error("power on under over-current");
endmodule

// File: verilog/ppc_ser_mem.sv
// byte memory holding the serial number string, registered read data
`timescale 1ns/100ps
`include "ppc_cfg.svh"
module ppc_ser_mem #(
   parameter int DEPTH = `PPC_SER_DEPTH,
   parameter int AW = `PPC_SER_AW
) (
   input wire logic ref_clk_in,
   input wire logic ce_in,
   input wire logic wr_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   // no reset: contents are cleared by the owner walking every location
   logic [7:0] mem [0:DEPTH-1];
   always_ff @(posedge ref_clk_in) begin
      if (ce_in) begin
         if (wr_in) begin
            mem[addr_in] <= wdata_in;
         end
         rdata_out <= mem[addr_in];
      end
   end
endmodule
